//--- rtl/converter_control.sv
// Purpose: control of a 10-bit successive-approximation converter
// Assumes: analog mux, reference switches, dac and comparator outside
// Notes:   registers over AXI4-Lite; one level interrupt
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps

module converter_control
#(
    parameter bit LARGE_PACKAGE = 1'b1
) (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [converter_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                            awvalid,
    output logic                                 awready,
    input  wire logic [converter_pkg::DATA_W-1:0] wdata,
    input  wire logic [3:0]                      wstrb,
    input  wire logic                            wvalid,
    output logic                                 wready,
    output logic [1:0]                           bresp,
    output logic                                 bvalid,
    input  wire logic                            bready,
    input  wire logic [converter_pkg::ADDR_W-1:0] araddr,
    input  wire logic                            arvalid,
    output logic                                 arready,
    output logic [converter_pkg::DATA_W-1:0]     rdata,
    output logic [1:0]                           rresp,
    output logic                                 rvalid,
    input  wire logic                            rready,
    input  wire logic                            comparator_high,
    output logic [converter_pkg::NUM_INPUTS-1:0] channel_route,
    output logic [converter_pkg::NUM_INPUTS-1:0] analog_pin_mask,
    output logic [1:0]                           reference_select,
    output logic                                 converter_enable,
    output logic                                 sample_hold,
    output logic [converter_pkg::RESULT_W-1:0]   dac_code,
    output logic                                 irq
);
    import converter_pkg::*;

    // ==================================================================
    // state
    logic                  aw_full_q, w_full_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0]     aw_addr_q, rd_addr_q;
    logic [7:0]            w_data_q;
    logic                  w_lane_q;
    logic [1:0]            bresp_q, rresp_q;
    logic [DATA_W-1:0]     rdata_q;
    logic                  on_q, go_q, justify_q, done_flag_q, done_mask_q;
    logic [3:0]            channel_select_q, pin_analog_config_q;
    logic [1:0]            reference_select_q;
    logic [2:0]            conversion_clock_select_q;
    logic [7:0]            result_high_byte_q, result_low_byte_q;
    logic [6:0]            div_q, tad_cnt_q;
    logic [3:0]            tad_idx_q;
    logic [RESULT_W-1:0]   sar_q, dac_q;
    logic [9:0]            conv_cyc_q;

    // ==================================================================
    // bus decode
    wire logic [4:0] wr_off  = {aw_addr_q[4:2], 2'b00};
    wire logic [4:0] rd_off  = {araddr[4:2], 2'b00};
    wire logic       wr_fire = aw_full_q && w_full_q && !bvalid_q;
    wire logic       rd_fire = arvalid && arready;
    wire logic       wr_en   = wr_fire && w_lane_q;
    wire logic       wr_ctrl0 = wr_en && (wr_off == OFF_CTRL_ZERO);
    wire logic       wr_ctrl1 = wr_en && (wr_off == OFF_CTRL_ONE);
    wire logic       wr_ctrl2 = wr_en && (wr_off == OFF_CTRL_TWO);
    wire logic       wr_mask  = wr_en && (wr_off == OFF_IRQ_MASK);
    wire logic       wr_hit   = (wr_off <= OFF_IRQ_MASK);
    wire logic       rd_hit   = (rd_off <= OFF_IRQ_MASK);
    wire logic       rd_status = rd_fire && (rd_off == OFF_IRQ_STATUS);

    assign awready = !aw_full_q;
    assign wready  = !w_full_q;
    assign arready = !rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;

    // ==================================================================
    // register views
    wire logic [7:0] ctrl0_view = {2'b00, channel_select_q, go_q, on_q};
    wire logic [7:0] ctrl1_view = {2'b00, reference_select_q, pin_analog_config_q};
    wire logic [7:0] ctrl2_view = {justify_q, 4'h0, conversion_clock_select_q};
    wire logic [7:0] rd_byte =
        (rd_off == OFF_CTRL_ZERO)   ? ctrl0_view :
        (rd_off == OFF_CTRL_ONE)    ? ctrl1_view :
        (rd_off == OFF_CTRL_TWO)    ? ctrl2_view :
        (rd_off == OFF_RESULT_HIGH) ? result_high_byte_q :
        (rd_off == OFF_RESULT_LOW)  ? result_low_byte_q :
        (rd_off == OFF_IRQ_STATUS)  ? {7'h00, done_flag_q} :
        (rd_off == OFF_IRQ_MASK)    ? {7'h00, done_mask_q} : 8'h00;

    // ==================================================================
    // conversion control
    wire logic new_on    = w_data_q[ON_BIT];
    // go may only rise from idle and with the module on in the same write
    wire logic start_conv = wr_ctrl0 && new_on && w_data_q[GO_BIT] && !go_q;
    wire logic tad_tick  = go_q && (tad_cnt_q == div_q - 7'h01);
    wire logic done_pulse = tad_tick && (tad_idx_q == TAD_PER_CONV - 4'h1);
    wire logic sar_step  = tad_tick && (tad_idx_q != 4'h0) && (tad_idx_q <= LAST_BIT_TAD);
    wire logic [RESULT_W-1:0] sar_keep = comparator_high ? dac_q : sar_q;
    wire logic [RESULT_W-1:0] next_trial = 10'h200 >> tad_idx_q;
    logic [6:0] div_sel;

    always_comb begin
        unique case (conversion_clock_select_q)
            3'b000:  div_sel = DIV2;
            3'b001:  div_sel = DIV8;
            3'b010:  div_sel = DIV32;
            3'b100:  div_sel = DIV4;
            3'b101:  div_sel = DIV16;
            3'b110:  div_sel = DIV64;
            3'b011, 3'b111: div_sel = RC_DIV_CYCLES;
        endcase
    end

    // ==================================================================
    // pin outputs
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_inputs
            localparam bit EXISTS = LARGE_PACKAGE || (gi < SMALL_INPUTS);
            assign channel_route[gi] = EXISTS && (channel_select_q == 4'(gi));
            assign analog_pin_mask[gi] = EXISTS &&
                (pin_analog_config_q != PCFG_ALL_DIGITAL) &&
                (5'(gi) + 5'(pin_analog_config_q) <= 5'(PCFG_LAST_INPUT) ||
                 pin_analog_config_q == 4'h0);
        end
    endgenerate

    assign reference_select = reference_select_q;
    assign converter_enable = on_q;
    assign sample_hold      = go_q;
    assign dac_code         = dac_q;
    assign irq              = done_flag_q && done_mask_q;

    // ==================================================================
    // bus channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                w_data_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
            rd_addr_q <= '0;
        end else begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_q  <= 1'b1;
                rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rdata_q   <= {24'h000000, rd_byte};
                rd_addr_q <= araddr;
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_q                      <= CTRL_RESET[ON_BIT];
            channel_select_q          <= CTRL_RESET[5:2];
            reference_select_q        <= CTRL_RESET[5:4];
            pin_analog_config_q       <= CTRL_RESET[3:0];
            justify_q                 <= CTRL_RESET[JUSTIFY_BIT];
            conversion_clock_select_q <= CTRL_RESET[2:0];
            done_mask_q               <= CTRL_RESET[DONE_BIT];
        end else begin
            if (wr_ctrl0) begin
                on_q             <= new_on;
                channel_select_q <= w_data_q[CHS_LSB +: 4];
            end
            if (wr_ctrl1) begin
                reference_select_q  <= w_data_q[REF_LSB +: 2];
                pin_analog_config_q <= w_data_q[PCFG_LSB +: 4];
            end
            if (wr_ctrl2) begin
                justify_q                 <= w_data_q[JUSTIFY_BIT];
                conversion_clock_select_q <= w_data_q[CLKSEL_LSB +: 3];
            end
            if (wr_mask) begin
                done_mask_q <= w_data_q[DONE_BIT];
            end
        end
    end

    // ==================================================================
    // conversion sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            go_q      <= 1'b0;
            div_q     <= DIV2;
            tad_cnt_q <= 7'h00;
            tad_idx_q <= 4'h0;
            sar_q     <= '0;
            dac_q     <= '0;
        end else if (start_conv) begin
            go_q      <= 1'b1;
            div_q     <= div_sel;
            tad_cnt_q <= 7'h00;
            tad_idx_q <= 4'h0;
            sar_q     <= '0;
            dac_q     <= 10'h200;
        end else if (go_q) begin
            // switching the module off aborts the conversion at once
            if (wr_ctrl0 && !new_on) begin
                go_q <= 1'b0;
            end else if (done_pulse) begin
                go_q <= 1'b0;
            end
            tad_cnt_q <= tad_tick ? 7'h00 : tad_cnt_q + 7'h01;
            if (tad_tick) begin
                tad_idx_q <= tad_idx_q + 4'h1;
            end
            if (sar_step) begin
                sar_q <= sar_keep;
                dac_q <= (tad_idx_q == LAST_BIT_TAD) ? sar_keep : (sar_keep | next_trial);
            end
        end
    end

    // ==================================================================
    // result and interrupt flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_high_byte_q <= RESULT_RESET;
            result_low_byte_q  <= RESULT_RESET;
            done_flag_q        <= 1'b0;
        end else begin
            if (done_pulse) begin
                result_high_byte_q <= justify_q ? {6'h00, sar_q[9:8]} : sar_q[9:2];
                result_low_byte_q  <= justify_q ? sar_q[7:0] : {sar_q[1:0], 6'h00};
            end
            // a completion in the cycle of a status read is kept
            if (done_pulse) begin
                done_flag_q <= 1'b1;
            end else if (rd_status) begin
                done_flag_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // checks
    always_ff @(posedge aclk) begin
        if (!aresetn || !go_q) begin
            conv_cyc_q <= 10'h000;
        end else begin
            conv_cyc_q <= conv_cyc_q + 10'h001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start_write;
        wr_ctrl0 && new_on && w_data_q[GO_BIT] && !go_q;
    endsequence

    sequence s_completion;
        done_pulse ##1 (!go_q && done_flag_q);
    endsequence

    a_go_needs_on: assert property (go_q |-> on_q)
        else $error("go set while converter off");
    a_off_write_stops: assert property (wr_ctrl0 && !new_on |=> !on_q && !go_q)
        else $error("clearing converter_on did not stop the module");
    a_start_go: assert property (s_start_write |=> go_q [*2])
        else $error("conversion did not start");
    a_conv_length: assert property (done_pulse |->
            conv_cyc_q == 10'(TAD_PER_CONV) * 10'(div_q) - 10'h001)
        else $error("conversion length wrong");
    a_done_updates: assert property (done_pulse |-> s_completion)
        else $error("completion effects missing");
    a_result_right: assert property (done_pulse && justify_q |=>
            result_low_byte_q == $past(sar_q[7:0]))
        else $error("right justified result wrong");
    a_no_restart: assert property (go_q && wr_ctrl0 && new_on && !done_pulse |=>
            go_q && conv_cyc_q == $past(conv_cyc_q) + 10'h001)
        else $error("conversion disturbed by write");
    a_unimpl_zero: assert property (rvalid_q && rd_addr_q[4:3] == 2'b00 |->
            rdata_q[7:6] == 2'b00)
        else $error("unimplemented bits not zero");
    a_small_package: assert property (!LARGE_PACKAGE && channel_select_q >= 4'hC
            |-> channel_route == '0 && analog_pin_mask[15:12] == 4'h0)
        else $error("missing channel selected");
    a_pin_digital: assert property (pin_analog_config_q == PCFG_ALL_DIGITAL
            |-> analog_pin_mask == '0)
        else $error("all digital config leaves an analog pin");
    a_read_clears: assert property (rd_status && !done_pulse |=> !done_flag_q && !irq)
        else $error("status read did not clear flag");

endmodule : converter_control

//--- rtl/converter_pkg.sv
// Purpose: shared constants for the converter control block
// Assumes: 32-bit AXI4-Lite register bus, 25 MHz aclk
// Notes:   all registers are 8 bits wide in byte lane 0
package converter_pkg;

    // ==================================================================
    // bus geometry
    localparam int          ADDR_W            = 5;
    localparam int          DATA_W            = 32;
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [4:0]  OFF_CTRL_ZERO     = 5'h00;
    localparam logic [4:0]  OFF_CTRL_ONE      = 5'h04;
    localparam logic [4:0]  OFF_CTRL_TWO      = 5'h08;
    localparam logic [4:0]  OFF_RESULT_HIGH   = 5'h0C;
    localparam logic [4:0]  OFF_RESULT_LOW    = 5'h10;
    localparam logic [4:0]  OFF_IRQ_STATUS    = 5'h14;
    localparam logic [4:0]  OFF_IRQ_MASK      = 5'h18;

    // ==================================================================
    // field positions
    localparam int          ON_BIT            = 0;
    localparam int          GO_BIT            = 1;
    localparam int          CHS_LSB           = 2;
    localparam int          REF_LSB           = 4;
    localparam int          PCFG_LSB          = 0;
    localparam int          JUSTIFY_BIT       = 7;
    localparam int          CLKSEL_LSB        = 0;
    localparam int          DONE_BIT          = 0;

    // ==================================================================
    // reset values
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [7:0]  RESULT_RESET      = 8'h00;

    // ==================================================================
    // conversion geometry and timing
    localparam int          RESULT_W          = 10;
    localparam int          NUM_INPUTS        = 16;
    localparam int          SMALL_INPUTS      = 12;
    localparam logic [3:0]  PCFG_ALL_DIGITAL  = 4'hF;
    localparam logic [3:0]  PCFG_LAST_INPUT   = 4'hE;
    localparam logic [3:0]  TAD_PER_CONV      = 4'hC;
    localparam logic [3:0]  LAST_BIT_TAD      = 4'hA;
    localparam int          CLK_PERIOD_NS     = 40;
    localparam int          RC_PERIOD_NS      = 1000;
    localparam logic [6:0]  RC_DIV_CYCLES     =
        7'((RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0]  DIV2              = 7'h02;
    localparam logic [6:0]  DIV4              = 7'h04;
    localparam logic [6:0]  DIV8              = 7'h08;
    localparam logic [6:0]  DIV16             = 7'h10;
    localparam logic [6:0]  DIV32             = 7'h20;
    localparam logic [6:0]  DIV64             = 7'h40;

endpackage : converter_pkg

//--- testbench/converter_control_tb.sv
// Purpose: self-checking bench for converter_control
// Assumes: comparator modelled as a fixed input level against dac_code
// Notes:   a small package copy shares the bus and is watched on its pins
`timescale 1ns/100ps

module converter_control_tb;
    import converter_pkg::*;
    // ==============================================================
    // signals
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        converter_enable, sample_hold, irq, comparator_high;
    logic [9:0]  vin;
    logic [15:0] route_small, pins_small;
    logic [4:0]  awaddr, araddr;
    logic [3:0]  wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, reference_select;
    logic [15:0] channel_route, analog_pin_mask;
    logic [9:0]  dac_code;
    int          n_mismatch, n_tests, hold_cnt;
    // each row: control zero, control one
    logic [7:0]  rows [6][2] = '{'{8'hC0, 8'hC0}, '{8'h06, 8'h11}, '{8'h2E, 8'hEE},
                                 '{8'h3E, 8'h3F}, '{8'h1C, 8'h07}, '{8'h20, 8'h00}};

    converter_control #(.LARGE_PACKAGE(1'b1)) DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .comparator_high(comparator_high),
        .channel_route(channel_route), .analog_pin_mask(analog_pin_mask),
        .reference_select(reference_select), .converter_enable(converter_enable),
        .sample_hold(sample_hold), .dac_code(dac_code), .irq(irq));

    // small package copy shares the bus; only its pin decode is watched
    converter_control #(.LARGE_PACKAGE(1'b0)) small_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(), .bresp(), .bvalid(), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(),
        .rresp(), .rvalid(), .rready(rready), .comparator_high(comparator_high),
        .channel_route(route_small), .analog_pin_mask(pins_small),
        .reference_select(), .converter_enable(), .sample_hold(),
        .dac_code(), .irq());

    // ideal comparator: the approximation should settle on vin itself
    assign comparator_high = (vin >= dac_code);

    initial aclk = 1'b0;
    always #20 aclk = ~aclk;
    // counts cycles with the hold switch open, to time a conversion
    // cleared while the switch is closed, so each conversion counts from zero
    always @(posedge aclk) hold_cnt <= (sample_hold === 1'b1) ? hold_cnt + 1 : 0;

    // ==============================================================
    // tasks
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic hung(input int k, input int lim);
        if (k >= lim) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : hung

    task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic [1:0] er);
        int k;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        hung(k, 100);
        chk(bresp, er);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
        int k;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rready <= 1'b0;
        hung(k, 100);
        chk(rresp, er);
        chk(rdata, {24'h0, e});
    endtask : rd

    task automatic conv(input int div);
        int k;
        for (k = 0; k < 2000; k++) begin
            @(posedge aclk);
            if (sample_hold === 1'b0) break;
        end
        hung(k, 2000);
        chk(hold_cnt, 12 * div);
    endtask : conv

    function automatic logic [15:0] pmask(input logic [3:0] c);
        if (c == 4'h0) return 16'hFFFF;
        if (c == 4'hF) return 16'h0000;
        return (16'h0001 << (15 - c)) - 16'h0001;
    endfunction : pmask

    // ==============================================================
    // sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        n_mismatch = 0;
        n_tests = 0;
        vin = 10'h3FF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_CTRL_ZERO, 8'h00, RESP_OKAY);
        rd(OFF_CTRL_ONE, 8'h00, RESP_OKAY);
        rd(OFF_CTRL_TWO, 8'h00, RESP_OKAY);
        chk(channel_route, 16'h0001);
        chk(analog_pin_mask, 16'hFFFF);
        chk(route_small, 16'h0001);
        chk(pins_small, 16'h0FFF);
        $display("reset test done");
        for (int j = 0; j < 6; j++) begin
            wr(OFF_CTRL_ZERO, rows[j][0], RESP_OKAY);
            wr(OFF_CTRL_ONE, rows[j][1], RESP_OKAY);
            rd(OFF_CTRL_ZERO, rows[j][0] & 8'h3C, RESP_OKAY);
            rd(OFF_CTRL_ONE, rows[j][1] & 8'h3F, RESP_OKAY);
            chk(channel_route, 16'h0001 << rows[j][0][5:2]);
            chk(reference_select, rows[j][1][5:4]);
            chk(analog_pin_mask, pmask(rows[j][1][3:0]));
            chk(route_small, rows[j][0][5:2] > 4'hB ? 16'h0 : 16'h1 << rows[j][0][5:2]);
            chk(pins_small, pmask(rows[j][1][3:0]) & 16'h0FFF);
            chk(sample_hold, 1'b0);
        end
        wr(5'h1C, 8'hFF, RESP_SLVERR);
        rd(5'h1C, 8'h00, RESP_SLVERR);
        $display("register table test done");
        // left justified, divide by 2, interrupt unmasked
        wr(OFF_IRQ_MASK, 8'h01, RESP_OKAY);
        wr(OFF_CTRL_TWO, 8'h00, RESP_OKAY);
        vin <= 10'h1B6;
        wr(OFF_CTRL_ZERO, 8'h03, RESP_OKAY);
        chk(converter_enable, 1'b1);
        rd(OFF_CTRL_ZERO, 8'h03, RESP_OKAY);
        conv(2);
        chk(dac_code, 10'h1B6);
        chk(irq, 1'b1);
        rd(OFF_RESULT_HIGH, 8'h6D, RESP_OKAY);
        rd(OFF_RESULT_LOW, 8'h80, RESP_OKAY);
        rd(OFF_CTRL_ZERO, 8'h01, RESP_OKAY);
        wr(OFF_RESULT_HIGH, 8'h00, RESP_OKAY);
        rd(OFF_RESULT_HIGH, 8'h6D, RESP_OKAY);
        rd(OFF_IRQ_STATUS, 8'h01, RESP_OKAY);
        chk(irq, 1'b0);
        rd(OFF_IRQ_STATUS, 8'h00, RESP_OKAY);
        $display("first conversion test done");
        // right justified, divide by 16, masked, second go ignored
        wr(OFF_CTRL_TWO, 8'h85, RESP_OKAY);
        wr(OFF_IRQ_MASK, 8'h00, RESP_OKAY);
        vin <= 10'h2A5;
        wr(OFF_CTRL_ZERO, 8'h03, RESP_OKAY);
        wr(OFF_CTRL_ZERO, 8'h03, RESP_OKAY);
        conv(16);
        chk(irq, 1'b0);
        rd(OFF_RESULT_HIGH, 8'h02, RESP_OKAY);
        rd(OFF_RESULT_LOW, 8'hA5, RESP_OKAY);
        wr(OFF_IRQ_MASK, 8'h01, RESP_OKAY);
        chk(irq, 1'b1);
        rd(OFF_IRQ_STATUS, 8'h01, RESP_OKAY);
        $display("second conversion test done");
        // internal RC clock, then switching off mid conversion aborts it
        wr(OFF_CTRL_TWO, 8'h07, RESP_OKAY);
        wr(OFF_CTRL_ZERO, 8'h03, RESP_OKAY);
        conv(RC_DIV_CYCLES);
        rd(OFF_IRQ_STATUS, 8'h01, RESP_OKAY);
        wr(OFF_CTRL_ZERO, 8'h03, RESP_OKAY);
        wr(OFF_CTRL_ZERO, 8'h00, RESP_OKAY);
        chk(sample_hold, 1'b0);
        chk(converter_enable, 1'b0);
        repeat (400) @(posedge aclk);
        rd(OFF_IRQ_STATUS, 8'h00, RESP_OKAY);
        rd(OFF_CTRL_ZERO, 8'h00, RESP_OKAY);
        $display("clock source and abort test done");
        // reset in mid conversion
        wr(OFF_CTRL_TWO, 8'h06, RESP_OKAY);
        wr(OFF_CTRL_ZERO, 8'h03, RESP_OKAY);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk(sample_hold, 1'b0);
        chk(converter_enable, 1'b0);
        chk(irq, 1'b0);
        rd(OFF_CTRL_ZERO, 8'h00, RESP_OKAY);
        rd(OFF_CTRL_TWO, 8'h00, RESP_OKAY);
        $display("abort by reset test done");
        wrap_up();
    end
endmodule : converter_control_tb
